//--- include/ddcnco_pkg.sv
/*
 * constants and types for the downconverter frequency translation stage.
 * assumes: one sample clock, control words held stable by a register block outside.
 */
package ddcnco_pkg;
    localparam int NCO_W = 48;
    localparam int SMP_W = 16;
    localparam int SLOTS = 16;
    localparam int SLOT_AW = 4;
    localparam int CTRL_W = 8;
    localparam int LUT_W = 6;
    // channel control register fields
    localparam int IF_MODE_LSB = 4;
    localparam int IF_MODE_W = 2;
    // nco control register fields
    localparam int SEL_MODE_LSB = 4;
    localparam int SEL_CHAN_LSB = 0;
    localparam logic [3:0] SEL_MODE_REG = 4'h0;
    // synchronization control register fields
    localparam int SYNC_SOFT_RST_BIT = 4;
    localparam int SYNC_SYSREF_EN_BIT = 0;
    localparam int SYNC_DDC_EN_BIT = 1;
    localparam logic [NCO_W-1:0] ACC_RESET = 48'h0000_0000_0000;
    localparam logic [NCO_W-1:0] ACC_ONE = 48'h0000_0000_0001;
    // 0.999 of positive full scale
    localparam logic signed [SMP_W-1:0] TEST_LEVEL = 16'h7fde;
    localparam int MIX_SHIFT = 15;
    localparam logic [LUT_W-1:0] QUARTER = 6'h10;

    typedef enum logic [IF_MODE_W-1:0] {
        DDCNCO_IF_VARIABLE,
        DDCNCO_IF_ZERO,
        DDCNCO_IF_FS4,
        DDCNCO_IF_TEST
    } ddcnco_if_mode_t;

    typedef logic [NCO_W-1:0] ddcnco_word_t;
    typedef logic signed [SMP_W-1:0] ddcnco_smp_t;
endpackage : ddcnco_pkg

//--- include/ddcnco_if.sv
/*
 * valid/ready stream carrier between the stage and its output buffer.
 * assumes: source holds data while valid and not ready.
 */
`timescale 1ns/1ps
interface ddcnco_strm_if #(parameter int W = 32);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ddcnco_strm_if

//--- verilog/ddcnco_slot_mem.sv
/*
 * shadow channel store: one write port, registered read port.
 * assumes: write and read on the same clock; read data lags address by one cycle.
 */
`timescale 1ns/1ps
module ddcnco_slot_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4,
    parameter int W = 96
) (
    input wire logic i_clk, // sample clock
    input wire logic i_wr, // write strobe
    input wire logic [AW-1:0] i_waddr, // write slot
    input wire logic [W-1:0] i_wdata, // write data
    input wire logic [AW-1:0] i_raddr, // read slot
    output logic [W-1:0] o_rdata // registered read data
);
    logic [W-1:0] mem [DEPTH];

    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("ddcnco_slot_mem: DEPTH must equal 2**AW");
    end

    always_ff @(posedge i_clk) begin
        if (i_wr) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule : ddcnco_slot_mem

//--- verilog/ddcnco_buf.sv
/*
 * small valid/ready fifo so a stalled receiver loses no word.
 * assumes: depth a power of two; output data registered in the store.
 */
`timescale 1ns/1ps
module ddcnco_buf #(
    parameter int W = 32,
    parameter int DEPTH = 2
) (
    input wire logic i_clk, // sample clock
    input wire logic i_reset_n, // async reset, active low
    ddcnco_strm_if.snk s_in, // filling side
    ddcnco_strm_if.src s_out // draining side
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] store [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_bad_depth
        $error("ddcnco_buf: DEPTH must be a power of two, at least 2");
    end

    assign s_in.ready = (count_reg != (AW+1)'(DEPTH));
    assign s_out.valid = (count_reg != '0);
    assign s_out.data = store[rptr_reg];
    assign push = s_in.valid && s_in.ready;
    assign pop = s_out.valid && s_out.ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            store[wptr_reg] <= s_in.data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : ddcnco_buf

//--- verilog/ddcnco_top.sv
/*
 * frequency translation stage of one downconverter channel: 48-bit complex
 * oscillator, quadrature mixer, 16 shadow tuning/phase slots, modulus logic.
 * assumes: sample clock is i_clk; control words come from a register block
 * on the same clock; i_sysref arrives asynchronously from a pin.
 */
//
// Contract
// - if mode comes from bits 5:4 of the channel control word.
// - variable mode runs oscillator and mixer; tuning word sets shift.
// - zero-if mode bypasses the mixer and stops the oscillator.
// - fs/4 mode mixes with a fixed quarter-rate sequence.
// - test mode forces input to 0.999 full scale, oscillator on.
// - 48-bit complex oscillator and quadrature mixer give complex baseband.
// - one oscillator per channel, producing exp of minus the carrier.
// - tuning word is signed 48-bit, spanning minus to plus half rate.
// - numerator and denominator are 48-bit unsigned; numerator below 2^47.
// - nonzero numerator enables modulus mode: rate is tuning plus num/den.
// - zero numerator disables modulus logic; only tuning word accumulates.
// - coherent mode hops freely without reset, phase tied to sync.
// - sixteen shadow slots each hold tuning and phase offset words.
// - a 48-bit phase offset word is added to the oscillator phase.
// - tuning and phase offset writes accepted anytime, phase stays deterministic.
// - accumulator resets to zero and advances every clock, except in zero-if mode and during resync.
// - soft reset bit high then low resets the accumulators.
// - sysref event resets accumulators when sysref and sync enables set.
// - one slot active; select mode zero picks slot from bits 3:0.
`timescale 1ns/1ps
module ddcnco_top
    import ddcnco_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic i_clk, // 200 MHz sample clock
    input wire logic i_reset_n, // async reset, active low
    input wire logic [ddcnco_pkg::CTRL_W-1:0] i_ddc_ctrl, // channel control word
    input wire logic [ddcnco_pkg::CTRL_W-1:0] i_nco_ctrl, // slot select mode and slot
    input wire logic [ddcnco_pkg::CTRL_W-1:0] i_sync_ctrl, // sync control word
    input wire logic i_sysref, // sysref pin, asynchronous
    input wire logic i_complex_in, // 1: input has q part
    input wire logic i_slot_wr, // pulse: write shadow slot
    input wire logic [ddcnco_pkg::SLOT_AW-1:0] i_slot_index, // slot written
    input wire ddcnco_pkg::ddcnco_word_t i_tuning_word, // signed tuning word
    input wire ddcnco_pkg::ddcnco_word_t i_phase_offset_word, // phase offset
    input wire ddcnco_pkg::ddcnco_word_t i_modulus_numerator_word, // modulus numerator
    input wire ddcnco_pkg::ddcnco_word_t i_modulus_denominator_word, // modulus denominator
    input wire logic i_in_valid, // input sample valid
    output logic o_in_ready, // stage can take a sample
    input wire ddcnco_pkg::ddcnco_smp_t i_in_i, // input i
    input wire ddcnco_pkg::ddcnco_smp_t i_in_q, // input q
    output logic o_out_valid, // output sample valid
    input wire logic i_out_ready, // filter chain takes sample
    output ddcnco_pkg::ddcnco_smp_t o_out_i, // baseband i
    output ddcnco_pkg::ddcnco_smp_t o_out_q, // baseband q
    output ddcnco_pkg::ddcnco_word_t o_phase_accumulator_word, // running phase
    output logic [ddcnco_pkg::SLOT_AW-1:0] o_active_slot // active shadow slot
);
    import ddcnco_pkg::*;

    localparam int PAIR_W = 2 * SMP_W;

    if (BUF_DEPTH < 2) begin : g_bad_buf_depth
        $error("ddcnco_top: BUF_DEPTH must be at least 2");
    end

    // quarter-wave cosine, n in 0..16
    function automatic ddcnco_smp_t quarter_cos(input logic [4:0] n);
        case (n)
            5'h00: quarter_cos = 16'sh7fff;
            5'h01: quarter_cos = 16'sh7f61;
            5'h02: quarter_cos = 16'sh7d8a;
            5'h03: quarter_cos = 16'sh7a7d;
            5'h04: quarter_cos = 16'sh7642;
            5'h05: quarter_cos = 16'sh70e3;
            5'h06: quarter_cos = 16'sh6a6e;
            5'h07: quarter_cos = 16'sh62f2;
            5'h08: quarter_cos = 16'sh5a82;
            5'h09: quarter_cos = 16'sh5134;
            5'h0a: quarter_cos = 16'sh471d;
            5'h0b: quarter_cos = 16'sh3c57;
            5'h0c: quarter_cos = 16'sh30fc;
            5'h0d: quarter_cos = 16'sh2528;
            5'h0e: quarter_cos = 16'sh18f9;
            5'h0f: quarter_cos = 16'sh0c8c;
            default: quarter_cos = 16'sh0000;
        endcase
    endfunction : quarter_cos

    // full-circle cosine from a 6-bit phase
    function automatic ddcnco_smp_t cos64(input logic [LUT_W-1:0] k);
        logic [4:0] idx;
        logic [4:0] mir;
        idx = {1'b0, k[3:0]};
        mir = 5'h10 - idx;
        case (k[5:4])
            2'h0: cos64 = quarter_cos(idx);
            2'h1: cos64 = -quarter_cos(mir);
            2'h2: cos64 = -quarter_cos(idx);
            default: cos64 = quarter_cos(mir);
        endcase
    endfunction : cos64

    // scale a mixer sum back to sample width with saturation
    function automatic ddcnco_smp_t sat_scale(input logic signed [PAIR_W:0] v);
        logic signed [PAIR_W:0] s;
        s = v >>> MIX_SHIFT;
        if (s > (PAIR_W+1)'(signed'(16'sh7fff))) begin
            sat_scale = 16'sh7fff;
        end else if (s < -(PAIR_W+1)'(33'sh8000)) begin
            sat_scale = 16'sh8000;
        end else begin
            sat_scale = s[SMP_W-1:0];
        end
    endfunction : sat_scale

    ddcnco_if_mode_t if_mode;
    assign if_mode = ddcnco_if_mode_t'(i_ddc_ctrl[IF_MODE_LSB +: IF_MODE_W]);

    // sysref: two flops, then edge detect on the second
    logic sysref_meta_reg;
    logic sysref_sync_reg;
    logic sysref_prev_reg;
    logic soft_rst_prev_reg;
    logic sysref_event;
    logic soft_rst_release;
    logic acc_resync;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sysref_meta_reg <= 1'b0;
            sysref_sync_reg <= 1'b0;
            sysref_prev_reg <= 1'b0;
        end else begin
            sysref_meta_reg <= i_sysref;
            sysref_sync_reg <= sysref_meta_reg;
            sysref_prev_reg <= sysref_sync_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            soft_rst_prev_reg <= 1'b0;
        end else begin
            soft_rst_prev_reg <= i_sync_ctrl[SYNC_SOFT_RST_BIT];
        end
    end

    assign sysref_event = sysref_sync_reg && !sysref_prev_reg
        && i_sync_ctrl[SYNC_SYSREF_EN_BIT] && i_sync_ctrl[SYNC_DDC_EN_BIT];
    // accumulators held while soft reset high and for one clock after its fall, then restart
    assign soft_rst_release = soft_rst_prev_reg && !i_sync_ctrl[SYNC_SOFT_RST_BIT];
    assign acc_resync = i_sync_ctrl[SYNC_SOFT_RST_BIT] || soft_rst_release
        || sysref_event;

    // shadow slot store: {tuning, phase offset}
    logic [SLOT_AW-1:0] active_slot_reg;
    logic [2*NCO_W-1:0] slot_rdata;
    ddcnco_word_t cur_tuning;
    ddcnco_word_t cur_phase_offset;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            active_slot_reg <= '0;
        end else if (i_nco_ctrl[SEL_MODE_LSB +: SLOT_AW] == SEL_MODE_REG) begin
            active_slot_reg <= i_nco_ctrl[SEL_CHAN_LSB +: SLOT_AW];
        end
    end

    ddcnco_slot_mem #(
        .DEPTH(SLOTS),
        .AW(SLOT_AW),
        .W(2 * NCO_W)
    ) u_slots (
        .i_clk(i_clk),
        .i_wr(i_slot_wr),
        .i_waddr(i_slot_index),
        .i_wdata({i_tuning_word, i_phase_offset_word}),
        .i_raddr(active_slot_reg),
        .o_rdata(slot_rdata)
    );

    // slot switch only swaps words, accumulator untouched
    assign cur_tuning = slot_rdata[NCO_W +: NCO_W];
    assign cur_phase_offset = slot_rdata[0 +: NCO_W];

    // modulus auxiliary accumulator
    logic modulus_on;
    ddcnco_word_t aux_acc_reg;
    logic [NCO_W:0] aux_sum;
    logic aux_wrap;

    assign modulus_on = (i_modulus_numerator_word != '0);
    assign aux_sum = {1'b0, aux_acc_reg} + {1'b0, i_modulus_numerator_word};
    assign aux_wrap = modulus_on && (aux_sum >= {1'b0, i_modulus_denominator_word});

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aux_acc_reg <= ACC_RESET;
        end else if (acc_resync || !modulus_on) begin
            aux_acc_reg <= ACC_RESET;
        end else if (aux_wrap) begin
            aux_acc_reg <= NCO_W'(aux_sum - {1'b0, i_modulus_denominator_word});
        end else begin
            aux_acc_reg <= aux_sum[NCO_W-1:0];
        end
    end

    // phase accumulator, wraps mod 2^48 so signed tuning is exact
    ddcnco_word_t phase_acc_reg;
    logic osc_on;

    assign osc_on = (if_mode != DDCNCO_IF_ZERO);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_acc_reg <= ACC_RESET;
        end else if (acc_resync || !osc_on) begin
            phase_acc_reg <= ACC_RESET;
        end else begin
            phase_acc_reg <= phase_acc_reg + cur_tuning
                + (aux_wrap ? ACC_ONE : ACC_RESET);
        end
    end

    // fs/4 phase sequence: 0, pi/2, pi, 3pi/2
    logic [1:0] quarter_cnt_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            quarter_cnt_reg <= '0;
        end else if (acc_resync || if_mode != DDCNCO_IF_FS4) begin
            quarter_cnt_reg <= '0;
        end else begin
            quarter_cnt_reg <= quarter_cnt_reg + 1'b1;
        end
    end

    // oscillator phase and complex exponential exp(-j*theta)
    ddcnco_word_t inst_phase;
    logic [LUT_W-1:0] lut_phase;
    ddcnco_smp_t lo_cos;
    ddcnco_smp_t lo_sin;

    assign inst_phase = phase_acc_reg + cur_phase_offset;
    assign lut_phase = (if_mode == DDCNCO_IF_FS4) ? {quarter_cnt_reg, 4'h0}
        : inst_phase[NCO_W-1 -: LUT_W];
    assign lo_cos = cos64(lut_phase);
    assign lo_sin = cos64(lut_phase - QUARTER);

    // input conditioning and mixing
    ddcnco_smp_t x_i;
    ddcnco_smp_t x_q;
    ddcnco_smp_t mix_i;
    ddcnco_smp_t mix_q;

    always_comb begin
        x_i = i_in_i;
        x_q = i_complex_in ? i_in_q : '0;
        if (if_mode == DDCNCO_IF_TEST) begin
            x_i = TEST_LEVEL;
            x_q = '0;
        end
    end

    // (x_i + j x_q)(cos - j sin)
    always_comb begin
        mix_i = sat_scale((PAIR_W+1)'(x_i * lo_cos) + (PAIR_W+1)'(x_q * lo_sin));
        mix_q = sat_scale((PAIR_W+1)'(x_q * lo_cos) - (PAIR_W+1)'(x_i * lo_sin));
        if (if_mode == DDCNCO_IF_ZERO) begin
            mix_i = x_i;
            mix_q = x_q;
        end
    end

    // output buffer, stalls input when full
    ddcnco_strm_if #(.W(PAIR_W)) s_mix ();
    ddcnco_strm_if #(.W(PAIR_W)) s_out ();

    assign s_mix.valid = i_in_valid;
    assign s_mix.data = {mix_i, mix_q};
    assign o_in_ready = s_mix.ready;

    ddcnco_buf #(
        .W(PAIR_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .s_in(s_mix),
        .s_out(s_out)
    );

    assign o_out_valid = s_out.valid;
    assign s_out.ready = i_out_ready;
    assign o_out_i = s_out.data[SMP_W +: SMP_W];
    assign o_out_q = s_out.data[0 +: SMP_W];
    assign o_phase_accumulator_word = phase_acc_reg;
    assign o_active_slot = active_slot_reg;
endmodule : ddcnco_top

//--- test/ddcnco_top_asserts.sv
/*
 * port checker for the translation stage, bound to ddcnco_top.
 * assumes: one clock, async active-low reset.
 */
`timescale 1ns/1ps
module ddcnco_top_asserts
    import ddcnco_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_reset_n, // reset, active low
    input wire logic [ddcnco_pkg::CTRL_W-1:0] i_ddc_ctrl, // channel control
    input wire logic [ddcnco_pkg::CTRL_W-1:0] i_nco_ctrl, // slot select
    input wire logic [ddcnco_pkg::CTRL_W-1:0] i_sync_ctrl, // sync control
    input wire logic i_sysref, // sysref pin
    input wire logic i_in_valid, // input valid
    input wire logic o_in_ready, // input ready
    input wire logic o_out_valid, // output valid
    input wire logic i_out_ready, // output ready
    input wire ddcnco_pkg::ddcnco_smp_t o_out_i, // out i
    input wire ddcnco_pkg::ddcnco_smp_t o_out_q, // out q
    input wire ddcnco_pkg::ddcnco_word_t o_phase_accumulator_word, // phase
    input wire logic [ddcnco_pkg::SLOT_AW-1:0] o_active_slot // active slot
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_reset_phase_zero: assert property ($rose(i_reset_n) |->
        o_phase_accumulator_word == '0 && o_active_slot == '0 && !o_out_valid)
        else $error("state not cleared by reset");
    a_zif_acc_held: assert property (i_ddc_ctrl[5:4] == 2'h1 |=>
        o_phase_accumulator_word == '0) else $error("acc moves in zero-if mode");
    a_soft_rst_high: assert property (i_sync_ctrl[4] |=>
        o_phase_accumulator_word == '0) else $error("acc moves under soft reset");
    a_soft_rst_tail: assert property ($fell(i_sync_ctrl[4]) |=>
        o_phase_accumulator_word == '0) else $error("acc not held after soft reset");
    a_sysref_resync: assert property ($rose(i_sysref) && i_sync_ctrl[1:0] == 2'h3 |->
        ##[1:6] o_phase_accumulator_word == '0) else $error("sysref missed");
    a_slot_follows: assert property (i_nco_ctrl[7:4] == 4'h0 |=>
        o_active_slot == $past(i_nco_ctrl[3:0])) else $error("slot not selected");
    a_slot_holds: assert property (i_nco_ctrl[7:4] != 4'h0 |=>
        $stable(o_active_slot)) else $error("slot moved in other select mode");
    a_out_hold: assert property (o_out_valid && !i_out_ready |=>
        o_out_valid && $stable(o_out_i) && $stable(o_out_q)) else $error("output dropped");
    a_full_refuse: assert property (!o_in_ready |-> o_out_valid)
        else $error("refusing while empty");
    a_first_answer: assert property (i_in_valid && o_in_ready && !o_out_valid |=>
        o_out_valid) else $error("no answer one cycle after take");
endmodule : ddcnco_top_asserts

bind ddcnco_top ddcnco_top_asserts i_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_ddc_ctrl(i_ddc_ctrl), .i_nco_ctrl(i_nco_ctrl), .i_sync_ctrl(i_sync_ctrl),
    .i_sysref(i_sysref), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
    .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_i(o_out_i),
    .o_out_q(o_out_q), .o_phase_accumulator_word(o_phase_accumulator_word),
    .o_active_slot(o_active_slot));

//--- test/ddcnco_sink_model.sv
/*
 * model of the decimating filter chain: takes words, may stall or go slow.
 * assumes: bench changes stall controls just after a rising edge.
 */
`timescale 1ns/1ps
module ddcnco_sink_model
    import ddcnco_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_valid, // word offered
    input wire ddcnco_pkg::ddcnco_smp_t i_i, // i part
    input wire ddcnco_pkg::ddcnco_smp_t i_q, // q part
    input wire logic i_stall, // hold ready low
    input wire logic i_slow, // ready every other cycle
    output logic o_ready // word taken
);
    logic tog = 1'b0;
    ddcnco_smp_t got_i[$];
    ddcnco_smp_t got_q[$];
    assign o_ready = !i_stall && (!i_slow || tog);
    always @(posedge i_clk) begin
        tog <= !tog;
        if (i_valid && o_ready) begin
            got_i.push_back(i_i);
            got_q.push_back(i_q);
        end
    end
endmodule : ddcnco_sink_model

//--- test/test_ddc_nco_frequency_translator.sv
/*
 * self-checking bench of the translation stage with a filter-chain model.
 * assumes: checker bound by its own file; inputs move 1 ns after each edge.
 */
`timescale 1ns/1ps
module test_ddc_nco_frequency_translator;
    import ddcnco_pkg::*;
    typedef struct {ddcnco_smp_t a; ddcnco_smp_t b; logic cx; ddcnco_smp_t eq;} ddcnco_row_t;
    logic i_clk = 0, i_reset_n = 0, i_sysref = 0, i_complex_in = 0, i_slot_wr = 0;
    logic i_in_valid = 0, stall = 0, slow = 0, hit, o_in_ready, o_out_valid, i_out_ready;
    logic [CTRL_W-1:0] i_ddc_ctrl = 8'h10, i_nco_ctrl = 8'h00, i_sync_ctrl = 8'h00;
    logic [SLOT_AW-1:0] i_slot_index = 4'h0, o_active_slot;
    ddcnco_word_t i_tuning_word = '0, i_phase_offset_word = '0, acc, a0, tp;
    ddcnco_word_t num = '0, den = 48'h0000_0000_0001;
    ddcnco_smp_t i_in_i = '0, i_in_q = '0, o_out_i, o_out_q;
    int failures = 0, n_checks = 0, k;
    int sl[3] = '{0, 5, 15};
    ddcnco_row_t rows[6] = '{'{16'h7fff, 16'h8000, 1, 16'h8000},
        '{16'h8000, 16'h7fff, 1, 16'h7fff}, '{16'h0001, 16'h1234, 0, 16'h0000},
        '{16'hfffe, 16'h0003, 1, 16'h0003}, '{16'h4321, 16'hedcb, 0, 16'h0000},
        '{16'h0000, 16'hffff, 1, 16'hffff}};

    initial forever #2.5 i_clk = ~i_clk;

    ddcnco_top i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ddc_ctrl(i_ddc_ctrl),
        .i_nco_ctrl(i_nco_ctrl), .i_sync_ctrl(i_sync_ctrl), .i_sysref(i_sysref),
        .i_complex_in(i_complex_in), .i_slot_wr(i_slot_wr), .i_slot_index(i_slot_index),
        .i_tuning_word(i_tuning_word), .i_phase_offset_word(i_phase_offset_word),
        .i_modulus_numerator_word(num), .i_modulus_denominator_word(den),
        .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .i_in_i(i_in_i), .i_in_q(i_in_q),
        .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_i(o_out_i),
        .o_out_q(o_out_q), .o_phase_accumulator_word(acc), .o_active_slot(o_active_slot));
    ddcnco_sink_model i_sink (.i_clk(i_clk), .i_valid(o_out_valid), .i_i(o_out_i),
        .i_q(o_out_q), .i_stall(stall), .i_slow(slow), .o_ready(i_out_ready));

    function automatic ddcnco_word_t tw(input int s);
        return (s == 15) ? 48'hffff_ffff_fff0 : 48'h0000_0000_0010 * (s + 1);
    endfunction : tw
    function automatic logic near(input logic signed [31:0] a, input logic signed [31:0] b);
        return (a - b <= 4) && (b - a <= 4);
    endfunction : near
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic send(input ddcnco_smp_t a, input ddcnco_smp_t b, input logic cx);
        logic took;
        took = 0;
        i_in_valid = 1;
        i_in_i = a;
        i_in_q = b;
        i_complex_in = cx;
        for (int n = 0; n < 40 && !took; n++) begin
            took = (o_in_ready === 1'b1);
            tick(1);
        end
        if (!took) begin
            failures++;
            report_and_stop();
        end
    endtask : send
    task automatic wait_out(input int n);
        for (int w = 0; w < 80 && i_sink.got_i.size() < n; w++) tick(1);
        if (i_sink.got_i.size() < n) begin
            failures++;
            report_and_stop();
        end
    endtask : wait_out
    task automatic resync();
        i_sink.got_i.delete();
        i_sink.got_q.delete();
        i_sync_ctrl = 8'h10;
        tick(2);
        chk(acc, '0);
        i_sync_ctrl = 8'h00;
        tick(2);
    endtask : resync
    task automatic step_is(input ddcnco_word_t t, input int c);
        a0 = acc;
        tick(c);
        chk(acc - a0, t);
    endtask : step_is

    initial begin
        tick(12);
        chk(o_out_valid, 0);
        chk(o_in_ready, 1);
        i_reset_n = 1;
        chk(acc, '0);
        chk(o_active_slot, 4'h0);
        for (k = 0; k < 16; k++) begin
            i_slot_wr = 1;
            i_slot_index = k;
            i_tuning_word = (k == 13 || k == 14) ? '0 : tw(k);
            i_phase_offset_word = (k == 13) ? 48'h4000_0000_0000 : '0;
            tick(1);
        end
        i_slot_wr = 0;
        i_ddc_ctrl = 8'h10;
        stall = 1;
        send(rows[0].a, rows[0].b, rows[0].cx);
        send(rows[1].a, rows[1].b, rows[1].cx);
        i_in_valid = 0;
        tick(2);
        chk(o_in_ready, 0);
        chk(acc, '0);
        stall = 0;
        slow = 1;
        for (k = 2; k < 6; k++) send(rows[k].a, rows[k].b, rows[k].cx);
        i_in_valid = 0;
        wait_out(6);
        for (k = 0; k < 6; k++) begin
            chk(i_sink.got_i[k], rows[k].a);
            chk(i_sink.got_q[k], rows[k].eq);
        end
        $display("test done: zero-if table");
        slow = 0;
        i_ddc_ctrl = 8'h00;
        tp = tw(0);
        for (k = 0; k < 3; k++) begin
            i_nco_ctrl = sl[k];
            for (int c = 0; c < 4; c++) begin
                a0 = acc;
                tick(1);
                chk((acc - a0 === tp) || (acc - a0 === tw(sl[k])), 1);
            end
            step_is(tw(sl[k]), 1);
            chk(o_active_slot, sl[k]);
            tp = tw(sl[k]);
        end
        i_nco_ctrl = 8'h37;
        tick(2);
        chk(o_active_slot, 4'hf);
        $display("test done: slot tuning");
        i_nco_ctrl = 8'h01;
        num = 48'h0000_0000_0001;
        den = 48'h0000_0000_0003;
        resync();
        step_is(48'h0000_0000_0061, 3);
        num = '0;
        resync();
        step_is(48'h0000_0000_0060, 3);
        $display("test done: modulus");
        for (int e = 0; e < 2; e++) begin
            i_sync_ctrl = e ? 8'h03 : 8'h00;
            tick(2);
            i_sysref = 1;
            hit = 0;
            for (int c = 0; c < 8; c++) begin
                tick(1);
                hit = hit | (acc === '0);
            end
            chk(hit, e[0]);
            i_sysref = 0;
            tick(2);
        end
        i_sync_ctrl = 8'h00;
        $display("test done: sysref");
        i_ddc_ctrl = 8'h20;
        resync();
        for (k = 0; k < 8; k++) send(16'h03e8, 16'h0000, 1);
        i_in_valid = 0;
        wait_out(8);
        for (k = 0; k < 4; k++) chk(i_sink.got_i[k + 4], i_sink.got_i[k]);
        for (k = 0; k < 2; k++) chk(near(i_sink.got_i[k], -i_sink.got_i[k + 2]), 1);
        $display("test done: quarter rate");
        i_ddc_ctrl = 8'h30;
        i_nco_ctrl = 8'h0e;
        resync();
        send(16'h0064, 16'h0000, 0);
        send(16'hec78, 16'h0007, 1);
        i_in_valid = 0;
        i_nco_ctrl = 8'h0d;
        tick(4);
        send(16'h0064, 16'h0000, 0);
        i_in_valid = 0;
        wait_out(3);
        chk(i_sink.got_i[1], i_sink.got_i[0]);
        chk(near(i_sink.got_i[0], TEST_LEVEL), 1);
        chk(near(i_sink.got_i[2], 0), 1);
        chk(near(i_sink.got_q[0], 0), 1);
        chk(near(i_sink.got_q[2], -TEST_LEVEL), 1);
        $display("test done: test mode");
        i_nco_ctrl = 8'h05;
        tick(2);
        i_reset_n = 0;
        tick(1);
        chk(acc, '0);
        chk(o_active_slot, 4'h0);
        chk(o_out_valid, 0);
        chk(o_in_ready, 1);
        i_reset_n = 1;
        tick(2);
        chk(o_active_slot, 4'h5);
        $display("test done: mid-run reset");
        report_and_stop();
    end
endmodule : test_ddc_nco_frequency_translator
